/* shared/efs_pkg.sv */
// constants, register map and carrier types of the encoder feedback supervisor
package efs_pkg;
  // clock rate and derived timing
  localparam int CLK_HZ     = 200_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int GATE_MS    = 10;              // speed gate window in ms
  localparam int RPM_SCALE  = 60000 / GATE_MS; // edges per gate to rpm numerator
  localparam int OW_REF_PCT = 1;               // open-wire arming level, % of max

  // register byte offsets
  localparam logic [7:0] OFS_PPR     = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_DIV     = 8'h08;
  localparam logic [7:0] OFS_OS_LVL  = 8'h0c;
  localparam logic [7:0] OFS_OS_DLY  = 8'h10;
  localparam logic [7:0] OFS_DEV_LVL = 8'h14;
  localparam logic [7:0] OFS_DEV_DLY = 8'h18;
  localparam logic [7:0] OFS_OW_DLY  = 8'h1c;
  localparam logic [7:0] OFS_AGREE   = 8'h20;
  localparam logic [7:0] OFS_MAX_RPM = 8'h24;
  localparam logic [7:0] OFS_SPEED   = 8'h28;
  localparam logic [7:0] OFS_STATUS  = 8'h2c;
  localparam logic [7:0] OFS_MASK    = 8'h30;

  // field positions
  localparam int CFG_DIR     = 0;
  localparam int CFG_OW_LSB  = 4;
  localparam int CFG_OS_LSB  = 8;
  localparam int CFG_DEV_LSB = 12;
  localparam int DIV_N_BIT   = 8;
  localparam int ST_OW       = 0;
  localparam int ST_OS       = 1;
  localparam int ST_DEV      = 2;
  localparam int ST_INDEX    = 3;
  localparam int ST_W        = 4;

  // reset values; delays are held in ms
  localparam logic [15:0] PPR_RST     = 16'd1024;
  localparam logic [3:0]  OW_STOP_RST = 4'h1;
  localparam logic [3:0]  OS_STOP_RST = 4'h1;
  localparam logic [3:0]  DEV_STOP_RST = 4'h3;
  localparam logic [5:0]  DIV_M_RST   = 6'd1;
  localparam logic        DIV_N_RST   = 1'b0;
  localparam logic [15:0] OS_LVL_RST  = 16'd115;  // 115 %
  localparam logic [15:0] OS_DLY_RST  = 16'd1000; // 1.0 s
  localparam logic [15:0] DEV_LVL_RST = 16'd10;   // 10 %
  localparam logic [15:0] DEV_DLY_RST = 16'd500;  // 0.5 s
  localparam logic [15:0] OW_DLY_RST  = 16'd2000; // 2.0 s
  localparam logic [15:0] AGREE_RST   = 16'd2;    // % of max speed
  localparam logic [15:0] MAX_RPM_RST = 16'd1800;

  typedef struct packed {
    logic [3:0] dev_stop;
    logic [3:0] os_stop;
    logic [3:0] ow_stop;
    logic       dir_sel;
  } efs_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } efs_enc_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01
  } efs_div_state_t;
endpackage

/* hdl/efs_top.sv */
// encoder feedback supervisor: decode, speed, pulse monitor, fault timers, apb
// Function
// RQ1 - speed scaled from programmable pulses per revolution, default 1024
// RQ2 - direction setting picks whether A-leads or B-leads means forward
// RQ3 - default direction treats A leading as forward rotation
// RQ4 - pulse monitor output divides encoder pulses by (1+n)/m
// RQ5 - monitor active only with two-phase card, ratio held within 1/32..1; code clamps only at 1, m up to 63 gives 1/63
// RQ6 - open wire needs running above 1% or min freq, no pulses for delay
// RQ7 - open wire fault stops with its own selector, default 1
// RQ8 - overspeed when speed exceeds level longer than delay, 115% and 1.0 s
// RQ9 - overspeed fault stops with its own selector, default 1
// RQ10 - deviation armed after speed agreement, fires past level for delay
// RQ11 - deviation fault stops with its own selector, default 3
// RQ12 - with a card fitted, speed monitor shows encoder-measured speed
// RQ13 - without a card, speed monitor shows the internal estimate
// RQ14 - accepts A/B inputs or A/B/Z inputs
// RQ15 - stop selector codes passed unchanged to stop control

// one delay timer: counts ms while its condition holds, pulses once on expiry
module efs_fault_timer #(
  parameter bit INCL = 1'b0  // 1: fire at delay, 0: fire after more than delay
) (
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // synchronised reset
  input  wire logic        tick,     // one-ms strobe
  input  wire logic        cond,     // fault condition level
  input  wire logic [15:0] delay,    // delay in ms
  output logic             hit       // one-cycle expiry pulse
);
  logic [16:0] cnt_reg;
  logic [16:0] thr;

  assign thr = INCL ? {1'b0, delay} : {1'b0, delay} + 17'h00001;

  // counter restarts whenever the condition drops, so only continuous time counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 17'h00000;
      hit     <= 1'b0;
    end
    else
    begin
      hit <= cond && tick && (cnt_reg + 17'h00001 == thr);
      if (!cond)
        cnt_reg <= 17'h00000;
      else if (tick && cnt_reg < thr)
        cnt_reg <= cnt_reg + 17'h00001;
    end
  end
endmodule

module efs_top #(
  parameter int CYC_PER_MS = efs_pkg::CYC_PER_MS  // cycles per ms tick
) (
  input  wire logic        clk_sys,        // 200 MHz clock
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic             pready,         // apb ready
  output logic [31:0]      prdata,         // apb read data
  output logic             pslverr,        // apb error, unmapped address
  input  wire efs_pkg::efs_enc_t enc_in,   // encoder phase pins
  input  wire logic        card_present,   // encoder card fitted pin
  input  wire logic        card_two_phase, // two-phase complementary card pin
  input  wire logic        run,            // drive running
  input  wire logic        above_min_freq, // reference above minimum frequency
  input  wire logic signed [15:0] ref_rpm, // speed reference, rpm
  input  wire logic signed [15:0] est_rpm, // internal speed estimate, rpm
  output logic signed [15:0] speed_monitor, // displayed speed, rpm
  output logic             pulse_mon_out,  // divided pulse monitor output
  output logic             stop_req,       // stop request level
  output logic [3:0]       stop_code,      // selected stop method code
  output logic             irq             // level interrupt
);
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // release reset through two flip-flops so every register leaves it together
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // pin synchronisers; only stage two is read
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end
    else
    begin
      pin_s1_reg <= {enc_in.a, enc_in.b, enc_in.z, card_present, card_two_phase};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic a_s, b_s, z_s, card_s, two_ph_s;
  assign {a_s, b_s, z_s, card_s, two_ph_s} = pin_s2_reg;

  // register file
  efs_pkg::efs_cfg_t cfg_reg;
  logic [15:0] ppr_reg, os_lvl_reg, os_dly_reg, dev_lvl_reg, dev_dly_reg;
  logic [15:0] ow_dly_reg, agree_reg, max_rpm_reg;
  logic [5:0]  div_m_reg;
  logic        div_n_reg;
  logic [efs_pkg::ST_W-1:0] status_reg, mask_reg, st_set;
  logic        wr_en, rd_ph;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_ph = psel && penable && !pready;

  // configuration writes take effect at the edge that completes the transfer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ppr_reg     <= efs_pkg::PPR_RST;
      cfg_reg     <= '{dev_stop: efs_pkg::DEV_STOP_RST, os_stop: efs_pkg::OS_STOP_RST,
                       ow_stop: efs_pkg::OW_STOP_RST, dir_sel: 1'b0};
      div_m_reg   <= efs_pkg::DIV_M_RST;
      div_n_reg   <= efs_pkg::DIV_N_RST;
      os_lvl_reg  <= efs_pkg::OS_LVL_RST;
      os_dly_reg  <= efs_pkg::OS_DLY_RST;
      dev_lvl_reg <= efs_pkg::DEV_LVL_RST;
      dev_dly_reg <= efs_pkg::DEV_DLY_RST;
      ow_dly_reg  <= efs_pkg::OW_DLY_RST;
      agree_reg   <= efs_pkg::AGREE_RST;
      max_rpm_reg <= efs_pkg::MAX_RPM_RST;
      mask_reg    <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        efs_pkg::OFS_PPR:     ppr_reg <= pwdata[15:0]; // RQ1
        efs_pkg::OFS_CFG:     cfg_reg <= '{dev_stop: pwdata[efs_pkg::CFG_DEV_LSB+:4],
                                           os_stop: pwdata[efs_pkg::CFG_OS_LSB+:4],
                                           ow_stop: pwdata[efs_pkg::CFG_OW_LSB+:4],
                                           dir_sel: pwdata[efs_pkg::CFG_DIR]};
        efs_pkg::OFS_DIV:
        begin
          div_m_reg <= pwdata[5:0];
          div_n_reg <= pwdata[efs_pkg::DIV_N_BIT];
        end
        efs_pkg::OFS_OS_LVL:  os_lvl_reg  <= pwdata[15:0];
        efs_pkg::OFS_OS_DLY:  os_dly_reg  <= pwdata[15:0];
        efs_pkg::OFS_DEV_LVL: dev_lvl_reg <= pwdata[15:0];
        efs_pkg::OFS_DEV_DLY: dev_dly_reg <= pwdata[15:0];
        efs_pkg::OFS_OW_DLY:  ow_dly_reg  <= pwdata[15:0];
        efs_pkg::OFS_AGREE:   agree_reg   <= pwdata[15:0];
        efs_pkg::OFS_MAX_RPM: max_rpm_reg <= pwdata[15:0];
        efs_pkg::OFS_MASK:    mask_reg    <= pwdata[efs_pkg::ST_W-1:0];
        default:              ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event in the clear cycle wins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= '0;
    else if (wr_en && paddr == efs_pkg::OFS_STATUS)
      status_reg <= (status_reg & ~pwdata[efs_pkg::ST_W-1:0]) | st_set;
    else
      status_reg <= status_reg | st_set;
  end

  // one wait state so read data leaves a flip-flop
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_ph)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (paddr)
        efs_pkg::OFS_PPR:     prdata[15:0] <= ppr_reg;
        efs_pkg::OFS_CFG:     prdata[15:0] <= {cfg_reg.dev_stop, cfg_reg.os_stop,
                                               cfg_reg.ow_stop, 3'h0, cfg_reg.dir_sel};
        efs_pkg::OFS_DIV:     prdata[8:0]  <= {div_n_reg, 2'h0, div_m_reg};
        efs_pkg::OFS_OS_LVL:  prdata[15:0] <= os_lvl_reg;
        efs_pkg::OFS_OS_DLY:  prdata[15:0] <= os_dly_reg;
        efs_pkg::OFS_DEV_LVL: prdata[15:0] <= dev_lvl_reg;
        efs_pkg::OFS_DEV_DLY: prdata[15:0] <= dev_dly_reg;
        efs_pkg::OFS_OW_DLY:  prdata[15:0] <= ow_dly_reg;
        efs_pkg::OFS_AGREE:   prdata[15:0] <= agree_reg;
        efs_pkg::OFS_MAX_RPM: prdata[15:0] <= max_rpm_reg;
        efs_pkg::OFS_SPEED:   prdata[15:0] <= speed_monitor;
        efs_pkg::OFS_STATUS:  prdata[efs_pkg::ST_W-1:0] <= status_reg;
        efs_pkg::OFS_MASK:    prdata[efs_pkg::ST_W-1:0] <= mask_reg;
        default:              pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // millisecond tick and speed gate
  logic [31:0] ms_cnt_reg;
  logic [7:0]  gate_cnt_reg;
  logic        tick, gate_end;
  assign tick     = (ms_cnt_reg == 32'(CYC_PER_MS - 1));
  assign gate_end = tick && (gate_cnt_reg == 8'(efs_pkg::GATE_MS - 1));
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_reg   <= 32'h0000_0000;
      gate_cnt_reg <= 8'h00;
    end
    else
    begin
      ms_cnt_reg <= tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
      if (gate_end)
        gate_cnt_reg <= 8'h00;
      else if (tick)
        gate_cnt_reg <= gate_cnt_reg + 8'h01;
    end
  end

  // x4 quadrature decode; a^b_prev is high when A leads B
  logic a_p_reg, b_p_reg, z_p_reg;
  logic step, up;
  logic signed [15:0] edge_cnt_reg;
  logic               edge_ms_reg;
  assign step = (a_s != a_p_reg) || (b_s != b_p_reg);
  assign up   = (a_s ^ b_p_reg) ^ cfg_reg.dir_sel; // RQ2 RQ3
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_p_reg      <= 1'b0;
      b_p_reg      <= 1'b0;
      z_p_reg      <= 1'b0;
      edge_cnt_reg <= 16'sh0000;
      edge_ms_reg  <= 1'b0;
    end
    else
    begin
      a_p_reg <= a_s;
      b_p_reg <= b_s;
      z_p_reg <= z_s;
      if (gate_end)
        edge_cnt_reg <= 16'sh0000;
      else if (step && card_s)
        edge_cnt_reg <= up ? edge_cnt_reg + 16'sh0001 : edge_cnt_reg - 16'sh0001;
      // pulse seen in the current ms; cleared at each tick
      if (tick)
        edge_ms_reg <= 1'b0;
      else if (step)
        edge_ms_reg <= 1'b1;
    end
  end

  // serial divider: rpm = |edges| * RPM_SCALE / (4 * ppr)
  efs_pkg::efs_div_state_t div_st_reg;
  logic [31:0] quo_reg, den_reg, quo_nx;
  logic [32:0] rem_reg, rem_sh;
  logic [4:0]  bit_reg;
  logic        neg_reg;
  logic signed [15:0] enc_rpm_reg;
  logic [15:0] abs_edges;
  assign abs_edges = edge_cnt_reg[15] ? 16'(-edge_cnt_reg) : edge_cnt_reg;
  assign rem_sh    = {rem_reg[31:0], quo_reg[31]};
  // quotient after this step, its new bit included, so the last step is not lost
  assign quo_nx    = {quo_reg[30:0], rem_sh >= {1'b0, den_reg}};
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_st_reg  <= efs_pkg::DIV_IDLE;
      quo_reg     <= 32'h0000_0000;
      den_reg     <= 32'h0000_0000;
      rem_reg     <= 33'h0_0000_0000;
      bit_reg     <= 5'h00;
      neg_reg     <= 1'b0;
      enc_rpm_reg <= 16'sh0000;
    end
    else
    begin
      unique case (div_st_reg)
        efs_pkg::DIV_IDLE:
        begin
          if (gate_end && ppr_reg != 16'h0000)
          begin
            quo_reg    <= 32'(abs_edges * efs_pkg::RPM_SCALE);
            den_reg    <= {14'h0000, ppr_reg, 2'b00}; // RQ1
            rem_reg    <= 33'h0_0000_0000;
            bit_reg    <= 5'h1f;
            neg_reg    <= edge_cnt_reg[15];
            div_st_reg <= efs_pkg::DIV_RUN;
          end
        end
        efs_pkg::DIV_RUN:
        begin
          rem_reg <= quo_nx[0] ? rem_sh - {1'b0, den_reg} : rem_sh;
          quo_reg <= quo_nx;
          bit_reg <= bit_reg - 5'h01;
          if (bit_reg == 5'h00)
          begin
            div_st_reg <= efs_pkg::DIV_IDLE;
            // saturate to 15 bits; the final quotient comes from quo_nx
            enc_rpm_reg <= 16'(neg_reg ? -$signed({1'b0, sat15(quo_nx)})
                                       : $signed({1'b0, sat15(quo_nx)}));
          end
        end
        default: div_st_reg <= efs_pkg::DIV_IDLE;
      endcase
    end
  end

  // clamp the unsigned quotient into the 15-bit magnitude of the display
  function automatic logic [14:0] sat15(input logic [31:0] q);
    sat15 = (q > 32'h0000_7fff) ? 15'h7fff : q[14:0];
  endfunction

  // speed display source
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      speed_monitor <= 16'sh0000;
    else
      speed_monitor <= card_s ? enc_rpm_reg : est_rpm; // RQ12 RQ13
  end

  // fault conditions in percent of max speed, cross-multiplied to avoid division
  logic [15:0] abs_spd, abs_ref, abs_dev;
  logic signed [16:0] dev_s;
  logic [31:0] max_x_os, max_x_dev, max_x_agr, max_x_ow;
  logic os_cond, dev_cond, ow_cond, agree, dev_armed_reg;
  logic ow_hit, os_hit, dev_hit;
  assign dev_s     = 17'(ref_rpm) - 17'(enc_rpm_reg);
  assign abs_spd   = enc_rpm_reg[15] ? 16'(-enc_rpm_reg) : enc_rpm_reg;
  assign abs_ref   = ref_rpm[15] ? 16'(-ref_rpm) : ref_rpm;
  assign abs_dev   = dev_s[16] ? 16'(-dev_s) : dev_s[15:0];
  assign max_x_os  = max_rpm_reg * os_lvl_reg;
  assign max_x_dev = max_rpm_reg * dev_lvl_reg;
  assign max_x_agr = max_rpm_reg * agree_reg;
  assign max_x_ow  = max_rpm_reg * 16'(efs_pkg::OW_REF_PCT);
  assign agree     = (abs_dev * 16'd100) <= max_x_agr;
  assign os_cond   = card_s && (abs_spd * 16'd100 > max_x_os);            // RQ8
  assign dev_cond  = card_s && dev_armed_reg &&
                     (abs_dev * 16'd100 > max_x_dev);                     // RQ10
  assign ow_cond   = card_s && run && !edge_ms_reg && !step &&
                     (above_min_freq || abs_ref * 16'd100 > max_x_ow);    // RQ6

  // deviation watch arms on first agreement in a run, disarms on stop
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dev_armed_reg <= 1'b0;
    else if (!run)
      dev_armed_reg <= 1'b0;
    else if (agree)
      dev_armed_reg <= 1'b1; // RQ10
  end

  efs_fault_timer #(.INCL(1'b1)) u_ow_tmr (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .tick  (tick),
    .cond  (ow_cond),
    .delay (ow_dly_reg),
    .hit   (ow_hit)
  );
  efs_fault_timer #(.INCL(1'b0)) u_os_tmr (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .tick  (tick),
    .cond  (os_cond),
    .delay (os_dly_reg),
    .hit   (os_hit)
  );
  efs_fault_timer #(.INCL(1'b0)) u_dev_tmr (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .tick  (tick),
    .cond  (dev_cond),
    .delay (dev_dly_reg),
    .hit   (dev_hit)
  );

  // index pulse seen only counts on the line-driver card (no two-phase flag)
  assign st_set = {card_s && !two_ph_s && z_s && !z_p_reg, dev_hit, os_hit, ow_hit}; // RQ14

  // stop request; open wire outranks overspeed outranks deviation
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_req  <= 1'b0;
      stop_code <= 4'h0;
      irq       <= 1'b0;
    end
    else
    begin
      irq      <= |(status_reg & mask_reg);
      stop_req <= |status_reg[efs_pkg::ST_DEV:efs_pkg::ST_OW];
      if (status_reg[efs_pkg::ST_OW])
        stop_code <= cfg_reg.ow_stop;  // RQ7 RQ15
      else if (status_reg[efs_pkg::ST_OS])
        stop_code <= cfg_reg.os_stop;  // RQ9 RQ15
      else if (status_reg[efs_pkg::ST_DEV])
        stop_code <= cfg_reg.dev_stop; // RQ11 RQ15
      else
        stop_code <= 4'h0;
    end
  end

  // pulse monitor: accumulate (1+n) per A edge, toggle output per m
  logic [6:0] acc_reg, inc, m_eff;
  assign m_eff = (div_m_reg == 6'd0) ? 7'd1 : {1'b0, div_m_reg};
  assign inc   = ({6'd0, div_n_reg} + 7'd1 > m_eff) ? m_eff
                 : {6'd0, div_n_reg} + 7'd1;                             // RQ5
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg       <= 7'd0;
      pulse_mon_out <= 1'b0;
    end
    else if (!(card_s && two_ph_s))
    begin
      acc_reg       <= 7'd0;
      pulse_mon_out <= 1'b0; // RQ5
    end
    else if (a_s != a_p_reg)
    begin
      if (acc_reg + inc >= m_eff)
      begin
        acc_reg       <= acc_reg + inc - m_eff;
        pulse_mon_out <= ~pulse_mon_out; // RQ4
      end
      else
        acc_reg <= acc_reg + inc;
    end
  end
endmodule

/* bench/efs_properties.sv */
// port-level relations the supervisor must keep at all times
module efs_props (
  input wire logic               clk_sys,        // system clock
  input wire logic               rst_b,          // async reset, active low
  input wire logic               psel,           // apb select
  input wire logic               penable,        // apb enable
  input wire logic [7:0]         paddr,          // apb byte address
  input wire logic               pready,         // apb ready
  input wire logic [31:0]        prdata,         // apb read data
  input wire logic               pslverr,        // apb error
  input wire logic               card_present,   // card fitted pin
  input wire logic               card_two_phase, // two-phase card pin
  input wire logic signed [15:0] est_rpm,        // internal estimate
  input wire logic signed [15:0] speed_monitor,  // displayed speed
  input wire logic               pulse_mon_out,  // monitor output
  input wire logic               stop_req,       // stop request
  input wire logic [3:0]         stop_code       // stop method code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // apb answer: one wait state, one cycle long, errors only off the map
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_unmapped: assert property (pready && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
  a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read with data");
  // sync delay of the card pins is covered by the five-cycle run
  a_est_shown: assert property (!card_present [*5] |-> speed_monitor == $past(est_rpm))
    else $error("estimate not shown without card");
  a_mon_quiet: assert property (!card_two_phase [*5] |-> !pulse_mon_out)
    else $error("monitor active without two-phase card");
  a_code_idle: assert property (!stop_req |-> stop_code == 4'h0)
    else $error("stop code without stop request");
endmodule

bind efs_top efs_props u_props (.clk_sys, .rst_b, .psel, .penable, .paddr, .pready, .prdata,
  .pslverr, .card_present, .card_two_phase, .est_rpm, .speed_monitor, .pulse_mon_out,
  .stop_req, .stop_code);

/* bench/efs_enc_model.sv */
// behavioural quadrature encoder on the motor shaft
module efs_enc_model (
  input  wire logic  clk, // system clock
  input  wire logic  en,  // shaft turning
  input  wire logic  fwd, // forward turning
  output efs_pkg::efs_enc_t enc // phase pins
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 5;  // clocks per quadrature edge
  localparam int PPR  = 10; // lines per turn, same as the bench setting
  int ph  = 0;
  int cnt = 0;
  // a stopped shaft holds its levels, so no edge reaches the open-wire timer
  always @(posedge clk)
  begin
    cnt <= (cnt + 1) % STEP;
    if (en && cnt == 0)
      ph <= fwd ? (ph + 1) % (4 * PPR) : (ph + 4 * PPR - 1) % (4 * PPR);
  end
  // forward turning makes a lead b; z marks one quarter per turn
  assign enc.a = ph[0] ^ ph[1];
  assign enc.b = ph[1];
  assign enc.z = (ph == 0);
endmodule

/* bench/testbench.sv */
// self-checking bench of the encoder feedback supervisor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 20; // short ms tick keeps delays in a few hundred cycles
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic card_present = 1'b0, card_two_phase = 1'b0, run = 1'b0, above_min_freq = 1'b0;
  logic en = 1'b0, fwd = 1'b1, mon_q = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic signed [15:0] ref_rpm = 16'sh0000, est_rpm = 16'sh0000, speed_monitor;
  logic pready, pslverr, pulse_mon_out, stop_req, irq;
  logic [3:0] stop_code;
  efs_pkg::efs_enc_t enc_in;
  int n_errors = 0, compares = 0, n_tog = 0;

  always #2.5 clk_sys = ~clk_sys;

  efs_top #(.CYC_PER_MS(CPM)) dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .enc_in, .card_present, .card_two_phase, .run,
    .above_min_freq, .ref_rpm, .est_rpm, .speed_monitor, .pulse_mon_out, .stop_req,
    .stop_code, .irq);
  efs_enc_model u_enc (.clk(clk_sys), .en, .fwd, .enc(enc_in));

  // count monitor output changes for the divider checks
  always @(posedge clk_sys)
  begin
    mon_q <= pulse_mon_out;
    if (mon_q !== pulse_mon_out)
      n_tog <= n_tog + 1;
  end

  task automatic check(input string nm, input logic [31:0] s, x);
    compares++;
    if (s !== x)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // edge counts drift by one with gate phase, hence a window
  task automatic near(input string nm, input logic signed [31:0] s, x, t);
    check(nm, 32'(s >= x - t && s <= x + t), 32'h1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one apb transfer; pready is sampled at rising edges, release follows the next edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++t < 50);
    check("pready", pready, 1'b1);
    q = prdata;
    e = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] rv [11] = '{32'h400, 32'h3110, 32'h1, 32'h73, 32'h3e8, 32'ha, 32'h1f4,
                             32'h7d0, 32'h2, 32'h708, 32'h0};
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, i == 10 ? 8'h30 : 8'(4 * i), 32'h0);
      check("reset value", q, rv[i]);
    end
    apb(1'b0, 8'h34, 32'h0);
    check("unmapped", {31'h0, e} | q, 32'h1);
  endtask

  task automatic t_speed;
    card_present <= 1'b1;
    card_two_phase <= 1'b0; // line-driver card, so the index pin counts
    en <= 1'b1;
    apb(1'b1, 8'h0c, 32'd1000);
    apb(1'b1, 8'h00, 32'd10);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h04, 32'h3110 + 32'(i > 0));
      fwd <= i < 2;
      cyc(700);
      near("speed", speed_monitor, i == 1 ? -6000 : 6000, 150);
    end
    apb(1'b0, 8'h2c, 32'h0);
    check("index seen", q[3], 1'b1);
    card_present <= 1'b0;
    est_rpm <= -16'sh04d2;
    cyc(10);
    check("estimate", 32'(speed_monitor), 32'(-16'sh04d2));
    card_present <= 1'b1;
  endtask

  task automatic t_pulse;
    logic [31:0] dv [5] = '{32'h4, 32'h102, 32'h101, 32'h20, 32'h4};
    int xp [5] = '{20, 80, 80, 2, 0};
    int t0;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 8'h08, dv[i]);
      card_two_phase <= i < 4;
      cyc(20);
      t0 = n_tog;
      cyc(800);
      near("pulse count", n_tog - t0, xp[i], 1);
    end
    card_two_phase <= 1'b1;
  endtask

  task automatic t_over;
    en <= 1'b0;
    apb(1'b1, 8'h0c, 32'd115);
    apb(1'b1, 8'h10, 32'd40);
    apb(1'b1, 8'h04, 32'h3910);
    apb(1'b1, 8'h30, 32'h7);
    cyc(500);
    apb(1'b1, 8'h2c, 32'hf);
    en <= 1'b1;
    cyc(780);
    check("os early", stop_req, 1'b0);
    cyc(800);
    check("os fault", {stop_req, irq, stop_code}, 6'h39);
    apb(1'b1, 8'h30, 32'h0);
    cyc(3);
    check("irq masked", irq, 1'b0);
    en <= 1'b0;
    cyc(500);
    apb(1'b1, 8'h2c, 32'hf);
    cyc(3);
    check("cleared", {stop_req, stop_code}, 5'h0);
  endtask

  task automatic t_ow;
    run <= 1'b1;
    apb(1'b1, 8'h1c, 32'd3);
    cyc(300);
    check("ow idle", stop_req, 1'b0);
    // first armed by the minimum-frequency flag, then by a 100 rpm reference, above the 1% level
    for (int i = 0; i < 2; i++)
    begin
      above_min_freq <= i == 0;
      ref_rpm <= i == 0 ? 16'sh0000 : 16'sh0064;
      cyc(300);
      check("ow fault", {stop_req, stop_code}, 5'h11);
      above_min_freq <= 1'b0;
      ref_rpm <= 16'sh0000;
      apb(1'b1, 8'h2c, 32'hf);
    end
    run <= 1'b0;
  endtask

  task automatic t_dev;
    apb(1'b1, 8'h0c, 32'd1000);
    apb(1'b1, 8'h18, 32'd5);
    apb(1'b1, 8'h20, 32'd10);
    fwd <= 1'b1;
    en <= 1'b1;
    ref_rpm <= 16'sh0bb8;
    cyc(600);
    run <= 1'b1;
    cyc(400);
    check("dev unarmed", stop_req, 1'b0);
    ref_rpm <= 16'sh1770;
    cyc(50);
    ref_rpm <= 16'sh0bb8;
    cyc(400);
    check("dev fault", {stop_req, stop_code}, 5'h13);
  endtask

  task automatic conclude;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reset for two cycles, then the scenarios in turn
  initial
  begin
    cyc(2);
    rst_b <= 1'b1;
    cyc(4);
    t_regs();
    t_speed();
    t_pulse();
    t_over();
    t_ow();
    t_dev();
    conclude();
  end
  // the run needs about 11k cycles; this cuts a hang short
  initial
  begin
    #200us;
    n_errors++;
    conclude();
  end
endmodule
